// >>> src/hps_top.sv
// hps_top.sv: host port mode selection, shared pin roles, interrupt pin,
// channel-b clear-to-send handling and gp/modem pin muxing
// assumes one 20 MHz clock, synchronous active-high reset, and a pad ring
// that resolves each open-drain or two-way pin from its output enable
`timescale 1ns/10ps
`default_nettype none
`include "hps_cfg.svh"

module hps_top (
	// clock and reset
	input wire logic CORE_CLK_I,
	input wire logic RESET_I,
	// strap and shared host pins
	input wire logic IF_SELECT_I,
	input wire logic SELECT_OR_ADDR_SEL_LO_I,
	input wire logic SERIAL_IN_OR_ADDR_SEL_HI_I,
	// serial output from the host engine and its pin
	input wire logic SPI_DATA_OUT_I,
	input wire logic SPI_RETURNING_I,
	output logic SPI_DATA_OUT_O,
	output logic SPI_DATA_OUT_OE_O,
	// decoded host port view
	output hps_pkg::hps_mode_t HOST_MODE_O,
	output logic SPI_SELECT_N_O,
	output logic SPI_DATA_IN_O,
	output logic [1:0] I2C_ADDR_SEL_O,
	// interrupt sources, enables and open-drain pin
	input wire hps_pkg::hps_int_vec_t INT_SOURCE_I,
	input wire hps_pkg::hps_int_vec_t INTERRUPT_ENABLE_REGISTER_I,
	output logic IRQ_N_O,
	output logic IRQ_N_OE_O,
	// channel-b clear-to-send
	input wire logic CLEAR_TO_SEND_CHAN_B_N_I,
	input wire logic [7:0] ENHANCED_FEATURES_REGISTER_I,
	output logic [7:0] MODEM_STATUS_REGISTER_O,
	output logic CHAN_B_XFER_ALLOW_O,
	// shared gp / modem pins
	input wire hps_pkg::hps_gp_vec_t GP_ROLE_MODEM_I,
	input wire hps_pkg::hps_gp_vec_t GP_OUT_I,
	input wire hps_pkg::hps_gp_vec_t GP_DIR_OUT_I,
	input wire logic TERMINAL_READY_B_N_I,
	input wire hps_pkg::hps_gp_vec_t GP_PIN_I,
	output logic [`HPS_GP_COUNT-1:0] GP_PIN_O,
	output logic [`HPS_GP_COUNT-1:0] GP_PIN_OE_O,
	output logic [`HPS_GP_COUNT-1:0] GP_IN_O,
	output logic SET_READY_B_N_O,
	output logic CARRIER_DETECT_B_N_O
);
	import hps_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// input synchronisers, two stages for every pin read by logic
	localparam int SYNC_W = 4 + `HPS_GP_COUNT;
	logic [SYNC_W-1:0] sync_a_reg, sync_a_next;
	logic [SYNC_W-1:0] sync_b_reg, sync_b_next;
	logic strap_s, sel_lo_s, sel_hi_s, cts_s;
	logic [`HPS_GP_COUNT-1:0] gp_s;

	// first stage feeds only the second stage
	always_comb begin
		sync_a_next = {GP_PIN_I, CLEAR_TO_SEND_CHAN_B_N_I, SERIAL_IN_OR_ADDR_SEL_HI_I,
			SELECT_OR_ADDR_SEL_LO_I, IF_SELECT_I};
		sync_b_next = sync_a_reg;
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (RESET_I) begin
			sync_a_reg <= '1; // idle-high pins: select and cts deasserted
			sync_b_reg <= '1;
		end else begin
			sync_a_reg <= sync_a_next;
			sync_b_reg <= sync_b_next;
		end
	end

	assign {gp_s, cts_s, sel_hi_s, sel_lo_s, strap_s} = sync_b_reg;

	////////////////////////////////////////////////////////////////////////
	// strap capture: once after reset, then frozen
	hps_mode_t mode_reg, mode_next;
	logic [1:0] settle_reg, settle_next;
	logic caught_reg, caught_next;

	// waits two edges so the synchroniser holds the real strap level
	always_comb begin
		mode_next = mode_reg;
		settle_next = settle_reg;
		caught_next = caught_reg;
		if (!caught_reg) begin
			if (settle_reg != 2'h2) begin
				settle_next = settle_reg + 2'h1;
			end else begin
				mode_next = strap_s ? HPS_MODE_I2C : HPS_MODE_SPI;
				caught_next = 1'b1;
			end
		end
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (RESET_I) begin
			mode_reg <= hps_mode_t'(`HPS_MODE_RESET);
			settle_reg <= 2'h0;
			caught_reg <= 1'b0;
		end else begin
			mode_reg <= mode_next;
			settle_reg <= settle_next;
			caught_reg <= caught_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// shared host pin roles
	logic is_i2c;
	assign is_i2c = (mode_reg == HPS_MODE_I2C) && caught_reg;
	assign HOST_MODE_O = mode_reg;

	// select is forced inactive in i2c mode and before the strap is known
	always_comb begin
		SPI_SELECT_N_O = 1'b1;
		SPI_DATA_IN_O = 1'b0;
		I2C_ADDR_SEL_O = 2'h0;
		if (is_i2c) begin
			I2C_ADDR_SEL_O = {sel_hi_s, sel_lo_s};
		end else if (caught_reg) begin
			SPI_SELECT_N_O = sel_lo_s;
			SPI_DATA_IN_O = sel_hi_s;
		end
	end

	// output stays floating in i2c mode; the board leaves it open
	always_comb begin
		SPI_DATA_OUT_O = SPI_DATA_OUT_I;
		SPI_DATA_OUT_OE_O = caught_reg && !is_i2c && SPI_RETURNING_I;
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt pin: drives low only, pull-up supplies the high level
	logic irq_reg, irq_next;

	always_comb begin
		irq_next = |(INT_SOURCE_I & INTERRUPT_ENABLE_REGISTER_I);
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (RESET_I) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= irq_next;
		end
	end

	assign IRQ_N_O = 1'b0;
	assign IRQ_N_OE_O = irq_reg;

	////////////////////////////////////////////////////////////////////////
	// channel-b clear-to-send status and gating
	logic [7:0] msr_reg, msr_next;
	logic allow_reg, allow_next;
	logic auto_cts;
	assign auto_cts = ENHANCED_FEATURES_REGISTER_I[`HPS_EFR_AUTO_CTS_BIT];

	// status bit shows the asserted sense: 1 while the remote is ready
	always_comb begin
		msr_next = 8'h00;
		msr_next[`HPS_MSR_CTS_BIT] = !cts_s;
		allow_next = auto_cts ? !cts_s : 1'b1;
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (RESET_I) begin
			msr_reg <= 8'h00;
			allow_reg <= 1'b0;
		end else begin
			msr_reg <= msr_next;
			allow_reg <= allow_next;
		end
	end

	assign MODEM_STATUS_REGISTER_O = msr_reg;
	assign CHAN_B_XFER_ALLOW_O = allow_reg;

	////////////////////////////////////////////////////////////////////////
	// gp / modem pin muxing: in modem role pin 1 outputs terminal-ready, 0 and 2 are inputs
	localparam hps_gp_vec_t MODEM_IS_OUT = 3'h2;
	logic [`HPS_GP_COUNT-1:0] gp_out_reg, gp_oe_reg;
	logic [`HPS_GP_COUNT-1:0] gp_out_next, gp_oe_next;

	genvar g;
	generate
		for (g = 0; g < `HPS_GP_COUNT; g++) begin : gp_mux
			always_comb begin
				if (GP_ROLE_MODEM_I[g]) begin
					gp_out_next[g] = TERMINAL_READY_B_N_I;
					gp_oe_next[g] = MODEM_IS_OUT[g];
				end else begin
					gp_out_next[g] = GP_OUT_I[g];
					gp_oe_next[g] = GP_DIR_OUT_I[g];
				end
			end
		end
	endgenerate

	always_ff @(posedge CORE_CLK_I) begin
		if (RESET_I) begin
			gp_out_reg <= '0;
			gp_oe_reg <= '0; // all pins inputs out of reset
		end else begin
			gp_out_reg <= gp_out_next;
			gp_oe_reg <= gp_oe_next;
		end
	end

	assign GP_PIN_O = gp_out_reg;
	assign GP_PIN_OE_O = gp_oe_reg;
	assign GP_IN_O = gp_s;
	// modem inputs read high (inactive) when the pin is in gpio role
	assign SET_READY_B_N_O = GP_ROLE_MODEM_I[0] ? gp_s[0] : 1'b1;
	assign CARRIER_DETECT_B_N_O = GP_ROLE_MODEM_I[2] ? gp_s[2] : 1'b1;

endmodule : hps_top

`default_nettype wire

// >>> src/hps_cfg.svh
// hps_cfg.svh: bit positions and reset values for the host port select block
// assumes inclusion by bare name from the package and the top module
`ifndef HPS_CFG_SVH
`define HPS_CFG_SVH

// modem status word, clear-to-send image bit
`define HPS_MSR_CTS_BIT 4
// enhanced features word, automatic clear-to-send enable bit
`define HPS_EFR_AUTO_CTS_BIT 7
// interrupt enable / source bit positions
`define HPS_INT_PIN_CHANGE 0
`define HPS_INT_RX_ERROR 1
`define HPS_INT_RX_DATA 2
`define HPS_INT_TX_SPACE 3
`define HPS_INT_MODEM 4
`define HPS_INT_WIDTH 5
// reset value of the latched host mode (spi)
`define HPS_MODE_RESET 1'b0
// number of shared general-purpose / modem pins
`define HPS_GP_COUNT 3

`endif

// >>> src/hps_pkg.sv
// hps_pkg.sv: types for the host port select block
// assumes hps_cfg.svh on the include path
`include "hps_cfg.svh"

package hps_pkg;

	// host port mode, latched from the strap after reset
	typedef enum logic [0:0] {
		HPS_MODE_SPI = 1'b0,
		HPS_MODE_I2C = 1'b1
	} hps_mode_t;

	// one bit per interrupt source
	typedef logic [`HPS_INT_WIDTH-1:0] hps_int_vec_t;

	// pin roles: 0 = general-purpose, 1 = modem line
	typedef logic [`HPS_GP_COUNT-1:0] hps_gp_vec_t;

endpackage : hps_pkg

// >>> verif/hps_props_properties.sv
// hps_props: timing checks on the host port select block pins
// assumes a bind into hps_top and inputs held stable around reset
`timescale 1ns/10ps
`default_nettype none
module hps_props (
	// clock, reset and watched ports
	input wire logic CORE_CLK_I, RESET_I, SPI_RETURNING_I, SPI_DATA_OUT_OE_O,
	input wire logic SELECT_OR_ADDR_SEL_LO_I, SERIAL_IN_OR_ADDR_SEL_HI_I,
	input wire logic SPI_SELECT_N_O, SPI_DATA_IN_O, IRQ_N_O, IRQ_N_OE_O,
	input wire logic CLEAR_TO_SEND_CHAN_B_N_I, CHAN_B_XFER_ALLOW_O,
	input wire logic [1:0] I2C_ADDR_SEL_O,
	input wire logic [7:0] ENHANCED_FEATURES_REGISTER_I, MODEM_STATUS_REGISTER_O,
	input wire hps_pkg::hps_mode_t HOST_MODE_O,
	input wire hps_pkg::hps_int_vec_t INT_SOURCE_I, INTERRUPT_ENABLE_REGISTER_I
);
	import hps_pkg::*;
	logic [2:0] cnt_reg, cnt_next;
	// edges since reset, saturating; sync chains are full after five
	always_comb cnt_next = (cnt_reg == 3'h7) ? cnt_reg : cnt_reg + 3'h1;
	always_ff @(posedge CORE_CLK_I) cnt_reg <= RESET_I ? 3'h0 : cnt_next;
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (RESET_I);
	sequence s_settled;
		cnt_reg >= 3'h5;
	endsequence
	a_so_drive_gate: assert property (s_settled |-> SPI_DATA_OUT_OE_O ==
		(HOST_MODE_O == HPS_MODE_SPI && SPI_RETURNING_I)) else $error("so enable wrong");
	a_irq_pin_low: assert property (IRQ_N_OE_O |-> !IRQ_N_O &&
		|$past(INTERRUPT_ENABLE_REGISTER_I)) else $error("irq level not low");
	a_irq_source_enable: assert property (!$past(RESET_I) |-> IRQ_N_OE_O ==
		|$past(INT_SOURCE_I & INTERRUPT_ENABLE_REGISTER_I)) else $error("irq wrong");
	a_mode_held: assert property (s_settled |-> $stable(HOST_MODE_O))
		else $error("host mode moved");
	a_cts_status_bit: assert property (s_settled |-> MODEM_STATUS_REGISTER_O ==
		{3'h0, !$past(CLEAR_TO_SEND_CHAN_B_N_I, 3), 4'h0}) else $error("status wrong");
	a_auto_cts_gate: assert property (s_settled |-> CHAN_B_XFER_ALLOW_O ==
		(!$past(ENHANCED_FEATURES_REGISTER_I[7]) || !$past(CLEAR_TO_SEND_CHAN_B_N_I, 3)))
		else $error("allow wrong");
	a_spi_pin_roles: assert property (s_settled ##0 HOST_MODE_O == HPS_MODE_SPI |->
		SPI_SELECT_N_O == $past(SELECT_OR_ADDR_SEL_LO_I, 2) && I2C_ADDR_SEL_O == 2'h0 &&
		SPI_DATA_IN_O == $past(SERIAL_IN_OR_ADDR_SEL_HI_I, 2)) else $error("spi roles");
	a_i2c_pin_roles: assert property (s_settled ##0 HOST_MODE_O == HPS_MODE_I2C |->
		SPI_SELECT_N_O && I2C_ADDR_SEL_O == {$past(SERIAL_IN_OR_ADDR_SEL_HI_I, 2),
		$past(SELECT_OR_ADDR_SEL_LO_I, 2)}) else $error("i2c roles");
endmodule : hps_props
bind hps_top hps_props hps_props_i (.*);
`default_nettype wire

// >>> verif/hps_host.sv
// hps_host: host side lines, pull-up on interrupt, floating data out
// assumes the host never reads the data out line in i2c mode
`timescale 1ns/10ps
`default_nettype none
module hps_host (
	// pins seen by the host
	input wire logic clk_i, irq_n_i, irq_oe_i, so_i, so_oe_i,
	// resolved lines
	output logic irq_line_o,
	output logic so_line_o
);
	logic last_reg = 1'b0;
	// open-drain line rests high through the pull-up
	assign irq_line_o = irq_oe_i ? irq_n_i : 1'b1;
	// released line shows the inverse of its last level, never a stale copy
	assign so_line_o = so_oe_i ? so_i : !last_reg;
	always_ff @(posedge clk_i) if (so_oe_i) last_reg <= so_i;
endmodule : hps_host
`default_nettype wire

// >>> verif/tb_top.sv
// tb_top: directed tests of mode select, pin roles, interrupt and cts
// assumes hps_top, hps_host and the bound checker are compiled first
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import hps_pkg::*;
	logic CORE_CLK_I = 0, RESET_I = 1, IF_SELECT_I = 0, SELECT_OR_ADDR_SEL_LO_I = 1;
	logic SERIAL_IN_OR_ADDR_SEL_HI_I = 0, SPI_DATA_OUT_I = 0, SPI_RETURNING_I = 0;
	logic CLEAR_TO_SEND_CHAN_B_N_I = 1, TERMINAL_READY_B_N_I = 1, irq_line, so_line;
	logic [7:0] ENHANCED_FEATURES_REGISTER_I = 8'h00, MODEM_STATUS_REGISTER_O;
	hps_int_vec_t INT_SOURCE_I = 5'h00, INTERRUPT_ENABLE_REGISTER_I = 5'h00;
	hps_gp_vec_t GP_ROLE_MODEM_I = 3'h0, GP_OUT_I = 3'h0, GP_DIR_OUT_I = 3'h0;
	hps_gp_vec_t GP_PIN_I = 3'h0;
	logic SPI_DATA_OUT_O, SPI_DATA_OUT_OE_O, SPI_SELECT_N_O, SPI_DATA_IN_O, IRQ_N_O;
	logic IRQ_N_OE_O, CHAN_B_XFER_ALLOW_O, SET_READY_B_N_O, CARRIER_DETECT_B_N_O;
	logic [1:0] I2C_ADDR_SEL_O;
	logic [2:0] GP_PIN_O, GP_PIN_OE_O, GP_IN_O;
	hps_mode_t HOST_MODE_O;
	int err_total = 0, total_checks = 0;
	// design, host model and clock
	hps_top hps_top_i (.*);
	hps_host hps_host_i (.clk_i(CORE_CLK_I), .irq_n_i(IRQ_N_O), .irq_oe_i(IRQ_N_OE_O),
		.so_i(SPI_DATA_OUT_O), .so_oe_i(SPI_DATA_OUT_OE_O), .irq_line_o(irq_line),
		.so_line_o(so_line));
	always #25 CORE_CLK_I = ~CORE_CLK_I;
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("mismatch at %0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	// every input change lands on a falling edge
	task automatic wt(input int n);
		repeat (n) @(negedge CORE_CLK_I);
	endtask : wt
	// strap must stay put until the first edge after release
	task automatic boot(input logic strap);
		RESET_I = 1'b1;
		IF_SELECT_I = strap;
		wt(2);
		RESET_I = 1'b0;
		wt(6);
	endtask : boot
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : end_of_test
	////////////////////////////////////////////////////////////////////////////
	// generous bound, the tests take under a hundred cycles
	initial begin
		#20000;
		err_total++;
		end_of_test();
	end
	initial begin
		boot(1'b0);
		chk(HOST_MODE_O, HPS_MODE_SPI);
		SELECT_OR_ADDR_SEL_LO_I = 0;
		SERIAL_IN_OR_ADDR_SEL_HI_I = 1;
		SPI_DATA_OUT_I = 1;
		SPI_RETURNING_I = 1;
		wt(3);
		chk({SPI_SELECT_N_O, SPI_DATA_IN_O, I2C_ADDR_SEL_O}, 8'h04);
		chk({SPI_DATA_OUT_OE_O, so_line}, 8'h03);
		SPI_DATA_OUT_I = 0;
		wt(1);
		chk({SPI_DATA_OUT_OE_O, so_line}, 8'h02);
		SPI_RETURNING_I = 0;
		wt(1);
		chk(SPI_DATA_OUT_OE_O, 8'h00);
		$display("spi roles done");
		for (int i = 0; i < 5; i++) begin
			INT_SOURCE_I = 5'h01 << i;
			INTERRUPT_ENABLE_REGISTER_I = ~(5'h01 << i);
			wt(2);
			chk(irq_line, 8'h01);
			INTERRUPT_ENABLE_REGISTER_I = 5'h1F;
			wt(2);
			chk(irq_line, 8'h00);
		end
		$display("interrupt done");
		for (int k = 0; k < 4; k++) begin
			ENHANCED_FEATURES_REGISTER_I = {k[1], 7'h00};
			CLEAR_TO_SEND_CHAN_B_N_I = k[0];
			wt(4);
			chk(MODEM_STATUS_REGISTER_O, {3'h0, !k[0], 4'h0});
			chk(CHAN_B_XFER_ALLOW_O, !k[1] || !k[0]);
		end
		$display("cts done");
		GP_DIR_OUT_I = 3'h5;
		GP_OUT_I = 3'h7;
		wt(2);
		chk({GP_PIN_OE_O, GP_PIN_O}, 8'h2F);
		chk({SET_READY_B_N_O, CARRIER_DETECT_B_N_O}, 8'h03);
		GP_ROLE_MODEM_I = 3'h7;
		TERMINAL_READY_B_N_I = 0;
		GP_PIN_I = 3'h4;
		wt(3);
		chk({SET_READY_B_N_O, CARRIER_DETECT_B_N_O, GP_PIN_OE_O, GP_PIN_O[1]}, 8'h14);
		chk(GP_IN_O, 8'h04);
		$display("gp roles done");
		boot(1'b1);
		SPI_RETURNING_I = 1;
		wt(3);
		chk(HOST_MODE_O, HPS_MODE_I2C);
		chk({SPI_DATA_OUT_OE_O, SPI_SELECT_N_O, I2C_ADDR_SEL_O}, 8'h06);
		SERIAL_IN_OR_ADDR_SEL_HI_I = 0;
		SELECT_OR_ADDR_SEL_LO_I = 1;
		wt(3);
		chk({SPI_DATA_IN_O, I2C_ADDR_SEL_O}, 8'h01);
		IF_SELECT_I = 0;
		wt(4);
		chk(HOST_MODE_O, HPS_MODE_I2C);
		$display("i2c roles done");
		end_of_test();
	end
endmodule : tb_top
`default_nettype wire
